// ---- tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, avs_read, avs_write, avs_waitrequest, wait_mode, stop_mode, break_active, ext_clk;
    logic ext_force, overflow_irq, wake_request;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [5:0] chan_compare_event, channel_irq, chan_capture_mode, chan_capture_event;
    logic [7:0] q, a, b, c;
    int errors, checked, cycles, n;
    tcp_timer i_dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_active(break_active), .break_clear_enable(1'b0),
        .external_count_clock(ext_clk), .chan_capture_mode(chan_capture_mode),
        .chan_capture_event(chan_capture_event),
        .chan_compare_event(chan_compare_event), .ext_pin_force_input(ext_force),
        .overflow_irq(overflow_irq), .channel_irq(channel_irq), .wake_request(wake_request));
    tcp_ext_src i_src (.clk(clk), .pin(ext_clk));
    always #20 clk = ~clk;
    task automatic give_verdict();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low; data taken at that edge only
    task automatic acc(input logic [4:0] ad, input logic wr, input logic [7:0] d, output logic [7:0] r);
        int k;
        k = 0;
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && k < 50) begin
            @(posedge clk);
            k++;
        end
        r = avs_readdata[7:0];
        if (k == 50) chk(16'h0, 16'h1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] ad, input logic [7:0] d);
        logic [7:0] r;
        acc(ad, 1'b1, d, r);
    endtask
    task automatic rd(input logic [4:0] ad, output logic [7:0] r);
        acc(ad, 1'b0, 8'h00, r);
    endtask
    task automatic wait_irq();
        n = 0;
        while (overflow_irq !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
    endtask
    initial begin
        clk = 0; srst = 1; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
        wait_mode = 0; stop_mode = 0; break_active = 0; chan_compare_event = 0;
        chan_capture_mode = 0; chan_capture_event = 0;
        errors = 0; checked = 0; cycles = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(tcp_pkg::OFS_CTRL, q); chk(q, 16'h20);
        rd(tcp_pkg::OFS_PER_HI, a); rd(tcp_pkg::OFS_PER_LO, b); chk({a, b}, 16'hFFFF);
        rd(tcp_pkg::OFS_CNT_HI, a); rd(tcp_pkg::OFS_CNT_LO, b); chk({a, b}, 16'h0000);
        rd(5'h1C, q); chk(q, 16'h00);
        $display("reset values done");
        wr(tcp_pkg::OFS_CTRL, 8'h10);
        repeat (10) @(posedge clk);
        rd(tcp_pkg::OFS_CNT_HI, q);
        repeat (30) @(posedge clk);
        rd(tcp_pkg::OFS_CNT_HI, q);
        wr(tcp_pkg::OFS_CTRL, 8'h20);
        rd(tcp_pkg::OFS_CNT_LO, a); rd(tcp_pkg::OFS_CNT_LO, b); rd(tcp_pkg::OFS_CNT_LO, c);
        chk(a != b, 1);
        chk(b, c);
        wr(tcp_pkg::OFS_CTRL, 8'h30);
        rd(tcp_pkg::OFS_CNT_HI, a); rd(tcp_pkg::OFS_CNT_LO, b); chk({a, b}, 16'h0000);
        rd(tcp_pkg::OFS_CTRL, q); chk(q, 16'h20);
        $display("latch and clear done");
        for (int i = 0; i < 2; i++) begin
            wr(tcp_pkg::OFS_CTRL, 8'h10);
            if (i == 0) stop_mode <= 1'b1; else break_active <= 1'b1;
            @(posedge clk);
            rd(tcp_pkg::OFS_CNT_LO, a);
            repeat (20) @(posedge clk);
            rd(tcp_pkg::OFS_CNT_LO, b); chk(a, b);
            rd(tcp_pkg::OFS_CNT_HI, q); rd(tcp_pkg::OFS_CNT_LO, q); chk(q, b);
            stop_mode <= 1'b0;
            break_active <= 1'b0;
            repeat (5) @(posedge clk);
            rd(tcp_pkg::OFS_CNT_LO, c); chk(c != b, 1);
        end
        $display("stop and break done");
        for (int k = 0; k < 7; k++) begin
            wr(tcp_pkg::OFS_CTRL, 8'h30 | 8'(k));
            wr(tcp_pkg::OFS_CTRL, 8'(k));
            repeat (100) @(posedge clk);
            rd(tcp_pkg::OFS_CNT_LO, q);
            chk(q >= (100 >> k) && q <= (100 >> k) + 3, 1);
        end
        wr(tcp_pkg::OFS_CTRL, 8'h37);
        repeat (2) @(posedge clk);
        chk(ext_force, 1);
        wr(tcp_pkg::OFS_CTRL, 8'h07);
        i_src.burst(5);
        repeat (10) @(posedge clk);
        rd(tcp_pkg::OFS_CNT_LO, q); chk(q, 16'h05);
        $display("clock select done");
        wr(tcp_pkg::OFS_CTRL, 8'h36);
        wr(tcp_pkg::OFS_PER_HI, 8'h00);
        wr(tcp_pkg::OFS_PER_LO, 8'h03);
        wr(tcp_pkg::OFS_CTRL, 8'h56);
        wait_irq(); chk(overflow_irq, 1);
        rd(tcp_pkg::OFS_CTRL, q); chk(q, 16'hC6);
        wait_mode <= 1'b1;
        repeat (3) @(posedge clk);
        chk(wake_request, 1);
        rd(tcp_pkg::OFS_CTRL, q); chk(q, 16'h00);
        wr(tcp_pkg::OFS_PER_LO, 8'h55);
        wait_mode <= 1'b0;
        @(posedge clk);
        rd(tcp_pkg::OFS_PER_LO, q); chk(q, 16'h03);
        wr(tcp_pkg::OFS_CTRL, 8'hC6);
        rd(tcp_pkg::OFS_CTRL, q); chk(q, 16'hC6);
        wr(tcp_pkg::OFS_CTRL, 8'h46);
        rd(tcp_pkg::OFS_CTRL, q); chk(q, 16'h46);
        rd(tcp_pkg::OFS_CNT_LO, q); chk(q <= 3, 1);
        wr(tcp_pkg::OFS_PER_HI, 8'h00);
        repeat (600) @(posedge clk);
        chk(overflow_irq, 0);
        wr(tcp_pkg::OFS_PER_LO, 8'h03);
        wait_irq(); chk(overflow_irq, 1);
        $display("overflow done");
        wr(tcp_pkg::OFS_CH_EN, 8'h01);
        chan_compare_event <= 6'h3F;
        @(posedge clk);
        chan_compare_event <= 6'h00;
        repeat (3) @(posedge clk);
        chk(channel_irq, 16'h01);
        rd(tcp_pkg::OFS_CH_FLAG, q); chk(q, 16'h3F);
        wr(tcp_pkg::OFS_CH_FLAG, 8'h00);
        rd(tcp_pkg::OFS_CH_FLAG, q); chk(q, 16'h00);
        wr(tcp_pkg::OFS_CTRL, 8'h66);
        chan_capture_mode <= 6'h3F;
        chan_capture_event <= 6'h3F;
        @(posedge clk);
        chan_capture_event <= 6'h00;
        rd(tcp_pkg::OFS_CH_FLAG, q); chk(q, 16'h00);
        wr(tcp_pkg::OFS_CTRL, 8'h46);
        chan_capture_event <= 6'h3F;
        @(posedge clk);
        chan_capture_event <= 6'h00;
        rd(tcp_pkg::OFS_CH_FLAG, q); chk(q, 16'h3F);
        break_active <= 1'b1;
        @(posedge clk);
        wr(tcp_pkg::OFS_CH_FLAG, 8'h00);
        rd(tcp_pkg::OFS_CH_FLAG, q); chk(q, 16'h3F);
        break_active <= 1'b0;
        @(posedge clk);
        wr(tcp_pkg::OFS_CH_FLAG, 8'h00);
        rd(tcp_pkg::OFS_CH_FLAG, q); chk(q, 16'h00);
        $display("channels done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire

// ---- tcp_ext_src.sv ----
`default_nettype none
module tcp_ext_src #(
    parameter int HALF = 3
) (
    input wire logic clk,
    output var logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle low between bursts; slow enough that each level spans several bus clocks
    initial pin = 1'b0;
    task automatic burst(input int n);
        repeat (n) begin
            repeat (HALF) @(posedge clk);
            pin <= 1'b1;
            repeat (HALF) @(posedge clk);
            pin <= 1'b0;
        end
    endtask
endmodule // tcp_ext_src
`default_nettype wire

// ---- tcp_pkg.sv ----
`default_nettype none
package tcp_pkg;
    // Byte addresses on the register bus, one word each
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_CNT_HI = 5'h04;
    localparam logic [4:0] OFS_CNT_LO = 5'h08;
    localparam logic [4:0] OFS_PER_HI = 5'h0C;
    localparam logic [4:0] OFS_PER_LO = 5'h10;
    localparam logic [4:0] OFS_CH_EN = 5'h14;
    localparam logic [4:0] OFS_CH_FLAG = 5'h18;
    // Control register fields, then reset values, channel count and prescaler width
    localparam int BIT_OVF = 7;
    localparam int BIT_IE = 6;
    localparam int BIT_HALT = 5;
    localparam int BIT_CLR = 4;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 3;
    localparam logic [2:0] DIV_EXT = 3'h7;
    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam int NCH = 6;
    localparam int PRESC_W = 6;
    typedef struct packed {
        logic ovf_flag;
        logic ovf_ie;
        logic halt;
        logic [2:0] div;
    } tcp_ctrl_s;
    localparam tcp_ctrl_s CTRL_RST = '{ovf_flag: 1'b0, ovf_ie: 1'b0, halt: 1'b1, div: 3'h0};
endpackage
`default_nettype wire

// ---- tcp_timer.sv ----
// Our own choices: the Avalon-MM slave port and the register offsets.
`default_nettype none
module tcp_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_clear_enable,
    input wire logic external_count_clock,
    input wire logic [5:0] chan_capture_mode,
    input wire logic [5:0] chan_capture_event,
    input wire logic [5:0] chan_compare_event,
    output logic ext_pin_force_input,
    output logic overflow_irq,
    output logic [5:0] channel_irq,
    output logic wake_request
);
    tcp_pkg::tcp_ctrl_s ctrl;
    logic [15:0] count;
    logic [15:0] period;
    logic [7:0] lo_buffer;
    logic lo_latched;
    logic period_pending;
    logic ovf_armed;
    logic [5:0] channel_event_flag;
    logic [5:0] channel_irq_enable;
    logic [5:0] ch_armed;
    logic [tcp_pkg::PRESC_W-1:0] presc;
    logic [2:0] ext_sync;
    logic ext_level;
    logic ext_level_q;
    logic go;
    logic wr;
    logic rd;
    logic clr_cmd;
    logic ctrl_wr;
    logic tick;
    logic advance;
    logic wrap;
    logic ovf_set;
    logic protect;
    logic [5:0] ch_event;
    logic [tcp_pkg::PRESC_W-1:0] div_mask;

    // Registers are dark in wait mode: the access completes but has no effect
    assign go = (avs_read | avs_write) & ~avs_waitrequest & ~wait_mode;
    assign wr = go & avs_write & avs_byteenable[0];
    assign rd = go & avs_read;
    assign ctrl_wr = wr & (avs_address == tcp_pkg::OFS_CTRL);
    assign clr_cmd = ctrl_wr & avs_writedata[tcp_pkg::BIT_CLR];
    assign protect = break_active & ~break_clear_enable;

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Read data loaded as waitrequest drops, so it is stable when sampled
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & avs_waitrequest) begin
            avs_readdata <= 32'h0000_0000;
            if (!wait_mode) begin
                unique case (avs_address)
                    tcp_pkg::OFS_CTRL: avs_readdata[7:0] <= {ctrl.ovf_flag, ctrl.ovf_ie, ctrl.halt,
                        1'b0, 1'b0, ctrl.div};
                    tcp_pkg::OFS_CNT_HI: avs_readdata[7:0] <= count[15:8];
                    tcp_pkg::OFS_CNT_LO: avs_readdata[7:0] <= lo_latched ? lo_buffer : count[7:0];
                    tcp_pkg::OFS_PER_HI: avs_readdata[7:0] <= period[15:8];
                    tcp_pkg::OFS_PER_LO: avs_readdata[7:0] <= period[7:0];
                    tcp_pkg::OFS_CH_EN: avs_readdata[5:0] <= channel_irq_enable;
                    tcp_pkg::OFS_CH_FLAG: avs_readdata[5:0] <= channel_event_flag;
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // External clock pin: three stages, level accepted when last two agree
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_sync <= 3'h0;
            ext_level <= 1'b0;
            ext_level_q <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], external_count_clock};
            if (ext_sync[1] == ext_sync[2]) begin
                ext_level <= ext_sync[2];
            end
            ext_level_q <= ext_level;
        end
    end

    always_comb begin
        div_mask = '0;
        for (int i = 0; i < tcp_pkg::PRESC_W; i++) begin
            if (i < int'(ctrl.div)) begin
                div_mask[i] = 1'b1;
            end
        end
    end

    assign tick = (ctrl.div == tcp_pkg::DIV_EXT) ? (ext_level & ~ext_level_q)
                                                 : ((presc & div_mask) == div_mask);
    assign advance = tick & ~ctrl.halt & ~break_active & ~stop_mode;
    assign wrap = advance & (count == period);
    assign ovf_set = wrap & ~period_pending;

    always_ff @(posedge clk) begin
        if (srst) begin
            presc <= '0;
        end else if (clr_cmd) begin
            presc <= '0;
        end else if (!stop_mode) begin
            presc <= presc + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count <= tcp_pkg::COUNT_RST;
        end else if (clr_cmd) begin
            count <= tcp_pkg::COUNT_RST;
        end else if (wrap) begin
            count <= tcp_pkg::COUNT_RST;
        end else if (advance) begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lo_latched <= 1'b0;
            lo_buffer <= 8'h00;
        end else if (rd && avs_address == tcp_pkg::OFS_CNT_HI && !lo_latched) begin
            lo_latched <= 1'b1;
            lo_buffer <= count[7:0];
        end else if (rd && avs_address == tcp_pkg::OFS_CNT_LO) begin
            lo_latched <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            period <= tcp_pkg::PERIOD_RST;
            period_pending <= 1'b0;
        end else if (wr && avs_address == tcp_pkg::OFS_PER_HI) begin
            period[15:8] <= avs_writedata[7:0];
            period_pending <= 1'b1;
        end else if (wr && avs_address == tcp_pkg::OFS_PER_LO) begin
            period[7:0] <= avs_writedata[7:0];
            period_pending <= 1'b0;
        end
    end

    // Control fields; the clear bit is never stored
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl.ovf_ie <= tcp_pkg::CTRL_RST.ovf_ie;
            ctrl.halt <= tcp_pkg::CTRL_RST.halt;
            ctrl.div <= tcp_pkg::CTRL_RST.div;
        end else if (ctrl_wr) begin
            ctrl.ovf_ie <= avs_writedata[tcp_pkg::BIT_IE];
            ctrl.halt <= avs_writedata[tcp_pkg::BIT_HALT];
            ctrl.div <= avs_writedata[tcp_pkg::DIV_LSB +: tcp_pkg::DIV_W];
        end
    end

    // Set beats clear; a fresh overflow disarms a half-done clear
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl.ovf_flag <= 1'b0;
            ovf_armed <= 1'b0;
        end else if (ovf_set) begin
            ctrl.ovf_flag <= 1'b1;
            ovf_armed <= 1'b0;
        end else if (ctrl_wr && !avs_writedata[tcp_pkg::BIT_OVF] && ovf_armed && !protect) begin
            ctrl.ovf_flag <= 1'b0;
            ovf_armed <= 1'b0;
        end else if (rd && avs_address == tcp_pkg::OFS_CTRL && ctrl.ovf_flag && !protect) begin
            ovf_armed <= 1'b1;
        end
    end

    // Captures in chan_capture_mode need counting allowed; compares pass as is except in stop mode, which blocks every event
    assign ch_event = stop_mode ? 6'h00
        : (chan_compare_event | (chan_capture_event & ~chan_capture_mode)
           | (chan_capture_event & chan_capture_mode & {6{~ctrl.halt & ~break_active}}));

    always_ff @(posedge clk) begin
        if (srst) begin
            channel_irq_enable <= 6'h00;
        end else if (wr && avs_address == tcp_pkg::OFS_CH_EN) begin
            channel_irq_enable <= avs_writedata[5:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            channel_event_flag <= 6'h00;
            ch_armed <= 6'h00;
        end else begin
            for (int i = 0; i < tcp_pkg::NCH; i++) begin
                if (ch_event[i]) begin
                    channel_event_flag[i] <= 1'b1;
                    ch_armed[i] <= 1'b0;
                end else if (wr && avs_address == tcp_pkg::OFS_CH_FLAG && !avs_writedata[i]
                             && ch_armed[i] && !protect) begin
                    channel_event_flag[i] <= 1'b0;
                    ch_armed[i] <= 1'b0;
                end else if (rd && avs_address == tcp_pkg::OFS_CH_FLAG && channel_event_flag[i] && !protect) begin
                    ch_armed[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            overflow_irq <= 1'b0;
            channel_irq <= 6'h00;
            wake_request <= 1'b0;
            ext_pin_force_input <= 1'b0;
        end else begin
            overflow_irq <= ctrl.ovf_flag & ctrl.ovf_ie;
            channel_irq <= channel_event_flag & channel_irq_enable;
            wake_request <= wait_mode & ((ctrl.ovf_flag & ctrl.ovf_ie)
                | (|(channel_event_flag & channel_irq_enable)));
            ext_pin_force_input <= (ctrl.div == tcp_pkg::DIV_EXT);
        end
    end

    sequence s_hi_write;
        wr && avs_address == tcp_pkg::OFS_PER_HI;
    endsequence

    sequence s_no_lo_write;
        !(wr && avs_address == tcp_pkg::OFS_PER_LO);
    endsequence

    a_wrap_to_zero: assert property (@(posedge clk) disable iff (srst)
        wrap && !clr_cmd |=> count == 16'h0000)
        else $error("counter did not restart at period");
    a_wrap_sets_flag: assert property (@(posedge clk) disable iff (srst)
        ovf_set |=> ctrl.ovf_flag)
        else $error("overflow flag not set");
    a_ovf_irq_out: assert property (@(posedge clk) disable iff (srst)
        ctrl.ovf_flag && ctrl.ovf_ie |=> overflow_irq)
        else $error("overflow request missing");
    a_chan_irq_gate: assert property (@(posedge clk) disable iff (srst)
        ch_event[0] |=> ##1 (channel_irq[0] == channel_irq_enable[0]) || $changed(channel_irq_enable[0]))
        else $error("channel request wrong");
    a_flag_set_wins: assert property (@(posedge clk) disable iff (srst)
        ovf_set && ctrl_wr |=> ctrl.ovf_flag)
        else $error("overflow lost to clear");
    a_one_write_keeps: assert property (@(posedge clk) disable iff (srst)
        ctrl.ovf_flag && ctrl_wr && avs_writedata[tcp_pkg::BIT_OVF] |=> ctrl.ovf_flag)
        else $error("writing one changed flag");
    a_stop_freeze: assert property (@(posedge clk) disable iff (srst)
        stop_mode && !clr_cmd |=> $stable(count))
        else $error("counter moved in stop");
    a_break_protect: assert property (@(posedge clk) disable iff (srst)
        protect && ctrl.ovf_flag |=> ctrl.ovf_flag)
        else $error("flag cleared in break");
    a_halt_clear_zero: assert property (@(posedge clk) disable iff (srst)
        clr_cmd && avs_writedata[tcp_pkg::BIT_HALT] |=> (count == 16'h0000)[*3])
        else $error("halted counter not held at zero");
    a_lo_latch_hold: assert property (@(posedge clk) disable iff (srst)
        lo_latched && !(rd && avs_address == tcp_pkg::OFS_CNT_LO) |=> $stable(lo_buffer))
        else $error("latched low byte changed");
    // A set launched in the high-write cycle itself lands one edge later and is legal
    a_period_gate: assert property (@(posedge clk) disable iff (srst)
        s_hi_write ##1 s_no_lo_write[*2] |-> !ctrl.ovf_flag || $past(ctrl.ovf_flag))
        else $error("overflow set while period pending");
    a_ext_input: assert property (@(posedge clk) disable iff (srst)
        ctrl.div == tcp_pkg::DIV_EXT |=> ext_pin_force_input)
        else $error("pin not forced to input");
    // Freezes must hold the count exactly; only a clear may move it
    a_halt_freeze: assert property (@(posedge clk) disable iff (srst)
        ctrl.halt && !clr_cmd |=> $stable(count))
        else $error("counter moved while halted");
    a_break_freeze: assert property (@(posedge clk) disable iff (srst)
        break_active && !clr_cmd |=> $stable(count))
        else $error("counter moved in break");
    a_clear_zero: assert property (@(posedge clk) disable iff (srst)
        clr_cmd |=> count == 16'h0000 && presc == '0)
        else $error("clear left counter or prescaler");
    a_wake_req: assert property (@(posedge clk) disable iff (srst)
        wait_mode && ctrl.ovf_flag && ctrl.ovf_ie |=> wake_request)
        else $error("no wake request in wait");
    a_wait_no_write: assert property (@(posedge clk) disable iff (srst)
        wait_mode && avs_write && !avs_waitrequest |=> $stable(period))
        else $error("register written in wait");
    // Compares still pass while halted, so they are masked out here
    a_capture_block: assert property (@(posedge clk) disable iff (srst)
        ctrl.halt |-> (ch_event & chan_capture_mode & ~chan_compare_event) == 6'h00)
        else $error("capture while halted");
    a_chan_set_wins: assert property (@(posedge clk) disable iff (srst)
        ch_event[0] |=> channel_event_flag[0])
        else $error("channel flag not set");
    a_period_reset: assert property (@(posedge clk) disable iff (srst)
        $past(srst) |-> period == tcp_pkg::PERIOD_RST)
        else $error("period not all ones after reset");

endmodule // tcp_timer
`default_nettype wire
